// ==== rrit_decode.sv ====
// Operation
// - decode ten address lines plus two chip selects and the rom-region select
// - each chip select is independently a select or an ignored port-b line
// - rom-region select splits rom from ram, i/o and timer space
// - rom read returns the byte chosen by address, bits 3..0 ignored
// - ram enable ignores address bit 8; bits 5..0 pick the byte
// - in i/o space bit 2 low picks port registers, high picks timer
// - bits 1..0 pick port-a data, port-a direction, port-b data, port-b direction
// - timer write: bits 1..0 pick prescale of 1, 8, 64 or 1024 clocks
// - timer write or count read: bit 3 enables timeout onto port-b line seven
// - bit 2 high bit 0 low reads count; bits 2 and 0 high read flag
// - each device answers its own nonzero code, up to seven form one rom
// - flag read puts flag on data bit seven, bits six to zero low
`timescale 1ns/100ps
`include "rrit_cfg.svh"

module rrit_decode #(
   parameter logic CS_FIRST_USED = 1'b1,
   parameter logic CS_SECOND_USED = 1'b0,
   parameter logic [2:0] ROM_CODE = 3'h1,
   parameter logic [2:0] NONROM_CODE = 3'h0,
   parameter logic [1:0] RAM_A76 = 2'h0,
   parameter logic IO_A8 = 1'b0,
   parameter logic [1:0] IO_A76 = 2'h0,
   parameter int RAM_DEPTH = 64
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [9:0] i_addr,
   input wire logic i_rw,
   input wire logic i_chip_select_first,
   input wire logic i_chip_select_second,
   input wire logic i_rom_region_select,
   input wire logic [7:0] i_data,
   output logic [7:0] o_data,
   output logic o_data_oe_n,
   output logic o_rom_en,
   output logic o_ram_en,
   output logic o_io_en,
   output logic [7:0] o_port_a_data,
   output logic [7:0] o_port_a_direction,
   output logic [7:0] o_port_b_data,
   output logic [7:0] o_port_b_direction,
   output logic o_timer_irq_en,
   output logic o_port_b_line_seven_n
);
   // =====================================================================
   // select decode
   logic [2:0] sel_code, care;
   logic rom_hit, nonrom_hit, ram_hit, io_hit, any_hit;
   logic reg_acc, tmr_acc, reg_wr, tmr_wr, cnt_rd, flag_rd, irq_upd;
   logic [1:0] reg_sel;
   logic [5:0] ram_idx;

   // compare a select code, skipping pins masked as port lines
   function automatic logic code_match(input logic [2:0] got, input logic [2:0] want,
                                       input logic [2:0] msk);
      code_match = ((got ^ want) & msk) == 3'h0;
   endfunction

   // bit-per-bit order: second select, first select, rom-region select
   assign sel_code = {i_chip_select_second, i_chip_select_first, i_rom_region_select};
   assign care = {CS_SECOND_USED, CS_FIRST_USED, 1'b1};
   // a zero rom code would collide with the ram/io code of a chain
   assign rom_hit = (ROM_CODE != 3'h0) && code_match(sel_code, ROM_CODE, care);
   assign nonrom_hit = !rom_hit && code_match(sel_code, NONROM_CODE, care);
   assign ram_hit = nonrom_hit && !i_addr[9] && (i_addr[7:6] == RAM_A76);
   assign io_hit = nonrom_hit && i_addr[9] && (i_addr[8] == IO_A8) && (i_addr[7:6] == IO_A76);
   assign any_hit = rom_hit || ram_hit || io_hit;

   // i/o space split: registers on bit 2 low, timer on bit 2 high
   assign reg_acc = io_hit && (i_addr[`RRIT_A_TIMER_SEL] != 1'b1);
   assign tmr_acc = io_hit && (i_addr[`RRIT_A_TIMER_SEL] == 1'b1);
   assign reg_sel = i_addr[1:0];
   assign reg_wr = reg_acc && !i_rw;
   assign tmr_wr = tmr_acc && !i_rw;
   assign cnt_rd = tmr_acc && i_rw && !i_addr[0];
   assign flag_rd = tmr_acc && i_rw && i_addr[0];
   // flag read leaves the pin enable alone, since bit 3 is a don't care there
   assign irq_upd = tmr_wr || cnt_rd;
   assign ram_idx = i_addr[5:0];

   // =====================================================================
   // storage
   logic [7:0] ram_ff [RAM_DEPTH];
   logic [7:0] pa_data_ff, pa_dir_ff, pb_data_ff, pb_dir_ff;
   logic irq_en_ff, irq_n_ff;
   logic [7:0] tmr_count;
   logic tmr_flag;

   // ram holds no reset value, like the array it stands for
   always_ff @(posedge i_clk) begin
      if (ram_hit && !i_rw) begin
         ram_ff[ram_idx] <= i_data;
      end
   end

   // port registers change only on their own write
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pa_data_ff <= `RRIT_PORT_RESET;
         pa_dir_ff <= `RRIT_PORT_RESET;
         pb_data_ff <= `RRIT_PORT_RESET;
         pb_dir_ff <= `RRIT_PORT_RESET;
      end else if (reg_wr) begin
         if (reg_sel == `RRIT_SEL_PORT_A_DATA) pa_data_ff <= i_data;
         else if (reg_sel == `RRIT_SEL_PORT_A_DIR) pa_dir_ff <= i_data;
         else if (reg_sel == `RRIT_SEL_PORT_B_DATA) pb_data_ff <= i_data;
         else pb_dir_ff <= i_data;
      end
   end

   // pin enable latched from bit 3; pin pulled low on flag while enabled
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         irq_en_ff <= 1'b0;
         irq_n_ff <= 1'b1;
      end else begin
         if (irq_upd) irq_en_ff <= i_addr[`RRIT_A_IRQ_EN];
         irq_n_ff <= !(irq_en_ff && tmr_flag);
      end
   end

   // timer loads and clears its flag only when its own space is hit
   rrit_timer #(
      .DIV_W(10)
   ) u_timer (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_load(tmr_wr),
      .i_load_val(i_data),
      .i_prescale(i_addr[1:0]),
      .i_access(tmr_wr || cnt_rd),
      .o_count(tmr_count),
      .o_flag(tmr_flag)
   );

   // =====================================================================
   // read path
   logic [7:0] rom_byte, reg_byte, rd_byte;
   logic rd_drive;

   // mask contents: arbitrary fill, indexed by address bits 9..4 only
   function automatic logic [7:0] mask_rom(input logic [5:0] idx);
      mask_rom = {idx ^ 6'h2a, 2'h1};
   endfunction

   assign rom_byte = mask_rom(i_addr[9:4]);
   assign reg_byte = (reg_sel == `RRIT_SEL_PORT_A_DATA) ? pa_data_ff :
                     (reg_sel == `RRIT_SEL_PORT_A_DIR) ? pa_dir_ff :
                     (reg_sel == `RRIT_SEL_PORT_B_DATA) ? pb_data_ff : pb_dir_ff;
   // rom write is meaningless and leaves the bus released
   assign rd_drive = i_rw && any_hit;
   assign rd_byte = rom_hit ? rom_byte :
                    ram_hit ? ram_ff[ram_idx] :
                    reg_acc ? reg_byte :
                    cnt_rd ? tmr_count :
                    flag_rd ? {tmr_flag, 7'h00} : `RRIT_DATA_IDLE;

   logic [7:0] data_ff;
   logic oe_n_ff, rom_en_ff, ram_en_ff, io_en_ff;

   // one cycle from address to answer; idle bus shows zero and stays off
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         data_ff <= `RRIT_DATA_IDLE;
         oe_n_ff <= 1'b1;
         rom_en_ff <= 1'b0;
         ram_en_ff <= 1'b0;
         io_en_ff <= 1'b0;
      end else begin
         data_ff <= rd_drive ? rd_byte : `RRIT_DATA_IDLE;
         oe_n_ff <= !rd_drive;
         rom_en_ff <= rom_hit && i_rw;
         ram_en_ff <= ram_hit;
         io_en_ff <= io_hit;
      end
   end

   assign o_data = data_ff;
   assign o_data_oe_n = oe_n_ff;
   assign o_rom_en = rom_en_ff;
   assign o_ram_en = ram_en_ff;
   assign o_io_en = io_en_ff;
   assign o_port_a_data = pa_data_ff;
   assign o_port_a_direction = pa_dir_ff;
   assign o_port_b_data = pb_data_ff;
   assign o_port_b_direction = pb_dir_ff;
   assign o_timer_irq_en = irq_en_ff;
   assign o_port_b_line_seven_n = irq_n_ff;

   // =====================================================================
   // checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   property p_rom_read;
      (rom_hit && i_rw) |=> (o_rom_en && !o_data_oe_n && o_data == {$past(i_addr[9:4]) ^ 6'h2a, 2'h1});
   endproperty
   a_rom_read: assert property (p_rom_read) else $error("rom read answer wrong");

   property p_rom_split;
      (!rom_hit) |=> !o_rom_en;
   endproperty
   a_rom_split: assert property (p_rom_split) else $error("rom enable without its code");

   property p_ram_ignores_a8;
      (nonrom_hit && !i_addr[9] && i_addr[7:6] == RAM_A76) |=> o_ram_en;
   endproperty
   a_ram_ignores_a8: assert property (p_ram_ignores_a8) else $error("ram enable depends on a8");

   property p_port_write;
      (io_hit && !i_rw && !i_addr[2] && i_addr[1:0] == `RRIT_SEL_PORT_A_DIR)
         |=> (o_port_a_direction == $past(i_data)) && $stable(o_port_a_data);
   endproperty
   a_port_write: assert property (p_port_write) else $error("port-a direction write wrong");

   property p_timer_is_a2_high;
      (io_hit && !i_rw && i_addr[2]) |=> $stable(o_port_a_data) && $stable(o_port_b_data);
   endproperty
   a_timer_is_a2_high: assert property (p_timer_is_a2_high) else $error("timer write hit a port");

   property p_irq_enable;
      (tmr_wr || cnt_rd) |=> (o_timer_irq_en == $past(i_addr[3]));
   endproperty
   a_irq_enable: assert property (p_irq_enable) else $error("pin enable not taken from a3");

   property p_irq_pin_off;
      (!o_timer_irq_en) [*2] |-> o_port_b_line_seven_n;
   endproperty
   a_irq_pin_off: assert property (p_irq_pin_off) else $error("pin low while disabled");

   property p_count_read;
      cnt_rd |=> (o_data == $past(tmr_count)) && !o_data_oe_n;
   endproperty
   a_count_read: assert property (p_count_read) else $error("count read wrong");

   property p_flag_read;
      flag_rd |=> (o_data[6:0] == 7'h00) && (o_data[7] == $past(tmr_flag));
   endproperty
   a_flag_read: assert property (p_flag_read) else $error("flag read wrong");

   property p_prescale_load;
      tmr_wr |=> (tmr_count == $past(i_data));
   endproperty
   a_prescale_load: assert property (p_prescale_load) else $error("timer load lost");

   property p_idle;
      !any_hit |=> o_data_oe_n && $stable(o_port_a_data) && $stable(o_port_b_direction)
                   && $stable(o_timer_irq_en);
   endproperty
   a_idle: assert property (p_idle) else $error("idle cycle drove bus or changed state");

   property p_rom_write_off;
      (rom_hit && !i_rw) |=> o_data_oe_n && !o_rom_en;
   endproperty
   a_rom_write_off: assert property (p_rom_write_off) else $error("rom write drove the bus");

   property p_ram_write;
      (ram_hit && !i_rw) |=> (ram_ff[$past(ram_idx)] == $past(i_data));
   endproperty
   a_ram_write: assert property (p_ram_write) else $error("ram write lost");

   property p_port_b_dir_write;
      (reg_wr && reg_sel == `RRIT_SEL_PORT_B_DIR)
         |=> (o_port_b_direction == $past(i_data)) && $stable(o_port_b_data);
   endproperty
   a_port_b_dir_write: assert property (p_port_b_dir_write) else $error("port-b direction write wrong");

   property p_port_read;
      (reg_acc && i_rw) |=> !o_data_oe_n && o_io_en && !o_rom_en && !o_ram_en;
   endproperty
   a_port_read: assert property (p_port_read) else $error("register read not answered");

   property p_flag_keeps_en;
      flag_rd |=> $stable(o_timer_irq_en);
   endproperty
   a_flag_keeps_en: assert property (p_flag_keeps_en) else $error("flag read moved the pin enable");

   property p_irq_pin_on;
      (o_timer_irq_en && tmr_flag) |=> !o_port_b_line_seven_n;
   endproperty
   a_irq_pin_on: assert property (p_irq_pin_on) else $error("pin high while timeout enabled");

   property p_no_drive_on_write;
      !i_rw |=> o_data_oe_n;
   endproperty
   a_no_drive_on_write: assert property (p_no_drive_on_write) else $error("bus driven after a write");

   property p_one_space;
      !(o_rom_en && (o_ram_en || o_io_en)) && !(o_ram_en && o_io_en);
   endproperty
   a_one_space: assert property (p_one_space) else $error("two spaces enabled at once");

   property p_prescale_1t;
      (tmr_wr && i_addr[1:0] == `RRIT_PRE_1T ##1 !tmr_wr) |=> (tmr_count == $past(i_data, 2) - 8'h01);
   endproperty
   a_prescale_1t: assert property (p_prescale_1t) else $error("divide by one did not tick");

   property p_prescale_8t;
      (tmr_wr && i_addr[1:0] == `RRIT_PRE_8T ##1 (!tmr_wr) [*6]) |=> (tmr_count == $past(i_data, 7));
   endproperty
   a_prescale_8t: assert property (p_prescale_8t) else $error("divide by eight ticked early");

   c_rom_read: cover property (rom_hit && i_rw);
   c_timeout: cover property (!tmr_flag ##1 tmr_flag);
   c_flag_read_set: cover property (flag_rd && tmr_flag);
   c_irq_pin: cover property (!o_port_b_line_seven_n);
   c_prescale_8t: cover property (tmr_wr && i_addr[1:0] == `RRIT_PRE_8T);
endmodule // rrit_decode

// ==== rrit_cfg.svh ====
`ifndef RRIT_CFG_SVH
`define RRIT_CFG_SVH

// =====================================================================
// register choice inside port space, address bits 1 and 0
`define RRIT_SEL_PORT_A_DATA 2'h0
`define RRIT_SEL_PORT_A_DIR 2'h1
`define RRIT_SEL_PORT_B_DATA 2'h2
`define RRIT_SEL_PORT_B_DIR 2'h3

// =====================================================================
// field positions on the address lines, and the flag bit on the data lines
`define RRIT_A_TIMER_SEL 2
`define RRIT_A_IRQ_EN 3
`define RRIT_A_RAM_IGNORED 8
`define RRIT_FLAG_BIT 7

// =====================================================================
// prescale codes on address bits 1 and 0, and their divider shifts
`define RRIT_PRE_1T 2'h0
`define RRIT_PRE_8T 2'h1
`define RRIT_PRE_64T 2'h2
`define RRIT_PRE_1024T 2'h3
`define RRIT_SHIFT_1T 4'h0
`define RRIT_SHIFT_8T 4'h3
`define RRIT_SHIFT_64T 4'h6
`define RRIT_SHIFT_1024T 4'ha

// =====================================================================
// reset, idle and timeout wrap values
`define RRIT_PORT_RESET 8'h00
`define RRIT_COUNT_RESET 8'h00
`define RRIT_WRAP_COUNT 8'hff
`define RRIT_DATA_IDLE 8'h00

`endif

// ==== rrit_pkg.sv ====
// =====================================================================
// shared types
package rrit_pkg;
   // timer phase, one-hot
   typedef enum logic [1:0] {
      RRIT_COUNTING = 2'b01,
      RRIT_EXPIRED = 2'b10
   } rrit_tmr_state_t;
endpackage

// ==== rrit_timer.sv ====
`timescale 1ns/100ps
`include "rrit_cfg.svh"

// =====================================================================
// interval timer: prescaler, 8-bit down counter, sticky timeout flag
module rrit_timer #(
   parameter int DIV_W = 10
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_load,
   input wire logic [7:0] i_load_val,
   input wire logic [1:0] i_prescale,
   input wire logic i_access,
   output logic [7:0] o_count,
   output logic o_flag
);
   rrit_pkg::rrit_tmr_state_t state_ff, nxt_state;
   logic [DIV_W-1:0] div_ff, nxt_div, mask_ff, nxt_mask;
   logic [7:0] count_ff, nxt_count;
   logic flag_ff, nxt_flag;
   logic tick, expire;

   // divide-by mask from the prescale code
   function automatic logic [DIV_W-1:0] mask_of(input logic [1:0] sel);
      logic [3:0] sh;
      sh = `RRIT_SHIFT_1T;
      if (sel == `RRIT_PRE_8T) sh = `RRIT_SHIFT_8T;
      else if (sel == `RRIT_PRE_64T) sh = `RRIT_SHIFT_64T;
      else if (sel == `RRIT_PRE_1024T) sh = `RRIT_SHIFT_1024T;
      mask_of = DIV_W'((1 << sh) - 1);
   endfunction

   // one tick each time the low divider bits are all ones
   assign tick = ((div_ff & mask_ff) == mask_ff);
   // only the first underflow after a load counts; the free run that follows never re-arms the flag
   assign expire = tick && (count_ff == 8'h00) && (state_ff == rrit_pkg::RRIT_COUNTING);

   // load restarts the interval; after timeout the count runs every clock
   always_comb begin
      nxt_state = state_ff;
      nxt_div = div_ff + DIV_W'(1);
      nxt_mask = mask_ff;
      nxt_count = count_ff;
      if (i_load) begin
         nxt_state = rrit_pkg::RRIT_COUNTING;
         nxt_div = '0;
         nxt_mask = mask_of(i_prescale);
         nxt_count = i_load_val;
      end else if (tick) begin
         nxt_count = count_ff - 8'h01;
         case (state_ff)
            rrit_pkg::RRIT_COUNTING: begin
               if (expire) begin
                  nxt_state = rrit_pkg::RRIT_EXPIRED;
                  nxt_mask = '0;
                  nxt_count = `RRIT_WRAP_COUNT;
               end
            end
            default: begin
               nxt_mask = '0;
            end
         endcase
      end
   end

   // a timeout sets the flag even when a load or read clears it on the same edge
   assign nxt_flag = expire || (flag_ff && !i_access);

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_ff <= rrit_pkg::RRIT_EXPIRED;
         div_ff <= '0;
         mask_ff <= '0;
         count_ff <= `RRIT_COUNT_RESET;
         flag_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         div_ff <= nxt_div;
         mask_ff <= nxt_mask;
         count_ff <= nxt_count;
         flag_ff <= nxt_flag;
      end
   end

   assign o_count = count_ff;
   assign o_flag = flag_ff;
endmodule // rrit_timer

// ==== rrit_cpu_model.sv ====
`timescale 1ns/100ps

// =====================================================================
// processor side: one bus access per clock, there is no strobe
module rrit_cpu_model (
   input wire logic i_clk,
   output logic [9:0] o_addr,
   output logic o_rw,
   output logic [2:0] o_sel,
   output logic [7:0] o_wdata
);
   // idle as a read that hits nothing; sel is {second, first, rom region}
   initial begin
      o_addr = 10'h000;
      o_rw = 1'b1;
      o_sel = 3'h6;
      o_wdata = 8'h5a;
   end

   // lines move after the falling edge and hold a whole cycle, over the sampling edge
   task automatic put(input logic [9:0] a, input logic rw, input logic [2:0] s, input logic [7:0] d);
      @(negedge i_clk);
      o_addr = a;
      o_rw = rw;
      o_sel = s;
      // a read leaves the data lines floating, so show a pattern that keeps changing
      o_wdata = rw ? ~o_wdata : d;
   endtask
endmodule // rrit_cpu_model

// ==== testbench.sv ====
`timescale 1ns/100ps

// =====================================================================
// bench for the address decoder, processor model on the far side
module testbench;
   logic i_clk;
   logic i_rst;
   logic [9:0] addr;
   logic rw;
   logic [2:0] sel;
   logic [7:0] wdata;
   logic [7:0] o_data;
   logic oe_n;
   logic rom_en;
   logic ram_en;
   logic io_en;
   logic [7:0] pa;
   logic [7:0] pad;
   logic [7:0] pb;
   logic [7:0] pbd;
   logic irq_en;
   logic l7_n;
   int fails;
   int n_checks;
   logic [7:0] m_reg [4];
   logic [7:0] m_ram [64];
   logic [63:0] m_ok;
   logic m_irq;
   logic [31:0] seed;

   rrit_cpu_model u_rrit_cpu_model (.i_clk(i_clk), .o_addr(addr), .o_rw(rw), .o_sel(sel), .o_wdata(wdata));

   rrit_decode u_rrit_decode (
      .i_clk(i_clk), .i_rst(i_rst), .i_addr(addr), .i_rw(rw), .i_chip_select_first(sel[1]),
      .i_chip_select_second(sel[2]), .i_rom_region_select(sel[0]), .i_data(wdata), .o_data(o_data),
      .o_data_oe_n(oe_n), .o_rom_en(rom_en), .o_ram_en(ram_en), .o_io_en(io_en), .o_port_a_data(pa),
      .o_port_a_direction(pad), .o_port_b_data(pb), .o_port_b_direction(pbd), .o_timer_irq_en(irq_en),
      .o_port_b_line_seven_n(l7_n)
   );

   // 25 MHz
   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task end_sim;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // several shifts per draw so that neighbouring draws are less alike
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      for (int k = 0; k < 11; k++) begin
         s = {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
      end
      return s;
   endfunction

   // one access; expected enables, data and register state come from the decode rules
   task automatic acc(input logic [9:0] a, input logic r, input logic [2:0] s, input logic [7:0] d,
                      output logic [7:0] rd);
      logic rom;
      logic ram;
      logic io;
      logic dc;
      logic [7:0] e;
      rom = (s[1:0] == 2'b01);
      ram = (s[1:0] == 2'b00) && !a[9] && (a[7:6] == 2'h0);
      io = (s[1:0] == 2'b00) && a[9] && !a[8] && (a[7:6] == 2'h0);
      u_rrit_cpu_model.put(a, r, s, d);
      @(posedge i_clk);
      #1;
      rd = o_data;
      chk("enables", {rom_en, ram_en, io_en}, {rom & r, ram, io});
      chk("drive", oe_n, !(r && (rom || ram || io)));
      e = 8'h00;
      dc = !(io && a[2]) && !(r && ram && !m_ok[a[5:0]]);
      if (r && rom) e = {a[9:4] ^ 6'h2a, 2'b01};
      if (r && ram) e = m_ram[a[5:0]];
      if (r && io) e = m_reg[a[1:0]];
      if (dc) chk("read_data", o_data, e);
      if (!r && ram) begin
         m_ram[a[5:0]] = d;
         m_ok[a[5:0]] = 1'b1;
      end
      if (!r && io && !a[2]) m_reg[a[1:0]] = d;
      if (io && a[2] && (!r || !a[0])) m_irq = a[3];
      chk("ports", {pa, pad, pb, pbd}, {m_reg[0], m_reg[1], m_reg[2], m_reg[3]});
      chk("irq_en", irq_en, m_irq);
   endtask

   // load 2 with one prescale code, poll the flag, then clear it with a count read
   task automatic tmr(input logic [1:0] pre);
      logic [7:0] rd;
      int n;
      int p;
      p = (pre == 2'h0) ? 1 : (pre == 2'h1) ? 8 : (pre == 2'h2) ? 64 : 1024;
      acc({8'h83, pre}, 1'b0, 3'h0, 8'h02, rd);
      if (pre == 2'h3) begin
         acc(10'h20c, 1'b1, 3'h0, 8'h00, rd);
         chk("count", rd, 8'h02);
      end
      n = 0;
      do begin
         acc(10'h205, 1'b1, 3'h0, 8'h00, rd);
         n++;
      end while (rd[7] !== 1'b1 && n < 3500);
      if (n >= 3500) begin
         fails++;
         end_sim;
      end
      chk("flag", rd, 8'h80);
      chk("ticks", (n >= 2 * p - 2) && (n <= 3 * p + 4), 1'b1);
      acc(10'h20d, 1'b1, 3'h0, 8'h00, rd);
      chk("line_seven", l7_n, 1'b0);
      acc(10'h204, 1'b1, 3'h0, 8'h00, rd);
      acc(10'h205, 1'b1, 3'h0, 8'h00, rd);
      chk("flag_clear", rd, 8'h00);
      chk("line_seven_off", l7_n, 1'b1);
   endtask

   // =====================================================================
   // main sequence
   initial begin
      logic [7:0] rd;
      logic [9:0] a;
      fails = 0;
      n_checks = 0;
      i_rst = 1'b1;
      m_reg = '{8'h00, 8'h00, 8'h00, 8'h00};
      m_ok = '0;
      m_irq = 1'b0;
      seed = 32'd78385;
      repeat (6) @(posedge i_clk);
      @(negedge i_clk);
      i_rst = 1'b0;
      chk("reset", {oe_n, l7_n, irq_en, o_data}, {3'b110, 8'h00});
      // every port register written back to back, then read
      for (int i = 0; i < 4; i++) acc({8'h80, i[1:0]}, 1'b0, 3'h0, 8'ha5 ^ i[7:0], rd);
      for (int i = 0; i < 4; i++) acc({8'h80, i[1:0]}, 1'b1, 3'h0, 8'h00, rd);
      // ram byte seen again with a8 flipped
      acc(10'h025, 1'b0, 3'h0, 8'h3c, rd);
      acc(10'h125, 1'b1, 3'h0, 8'h00, rd);
      // rom write refused, rom read with the unused select high
      acc(10'h3f0, 1'b0, 3'h1, 8'hff, rd);
      acc(10'h3f5, 1'b1, 3'h5, 8'h00, rd);
      for (int i = 0; i < 4; i++) tmr(i[1:0]);
      // random traffic; timer space is kept out so the timer model stays simple
      repeat (400) begin
         seed = lfsr(seed);
         a = seed[9:0] & 10'h3fb;
         if (seed[31]) a[7:6] = 2'h0;
         acc(a, seed[10], seed[13:11], seed[21:14], rd);
      end
      end_sim;
   end
endmodule // testbench
